// *** common/seu_queue_pkg.sv ***
package seu_queue_pkg;

  // Clock and millisecond time base
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned ONE_MS_PS = 1000000000;
  localparam int unsigned MS_CYCLES = ONE_MS_PS / CLK_PERIOD_PS;

  // Check interval limits and queue size
  localparam logic [13:0] INTERVAL_MAX_MS = 14'h2710;
  localparam int QUEUE_DEPTH = 4;
  localparam int SECTOR_COUNT = 8;

  // Register offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_INTERVAL = 5'h04;
  localparam logic [4:0] OFS_PRIO = 5'h08;
  localparam logic [4:0] OFS_MITIG_OFF = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  // Control fields and reset values
  localparam int CTRL_DETECT_BIT = 0;
  localparam int CTRL_SCRUB_BIT = 1;
  localparam int CTRL_PIN_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [13:0] INTERVAL_RESET = 14'h0000;

  // Status fields
  localparam int STAT_COUNT_LO = 0;
  localparam int STAT_PEND_BIT = 4;
  localparam int STAT_DROP_LO = 8;

  // Message fields
  localparam int SECT_ADDR_LO = 16;
  localparam int SECT_CNT_LO = 0;
  localparam int LOC_TYPE_LO = 29;
  localparam int LOC_FIXED_BIT = 28;
  localparam int LOC_POS_LO = 12;
  localparam int LOC_IDX_LO = 0;
  localparam logic [2:0] TYPE_SINGLE = 3'h1;
  localparam logic [2:0] TYPE_MULTI = 3'h2;

  typedef enum logic [2:0] {
    ST_PICK = 3'h1,
    ST_WAIT = 3'h2,
    ST_FIX = 3'h4
  } scan_state_type;

endpackage : seu_queue_pkg

// *** hw/configuration_memory_seu_error_queue.sv ***
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps

// Function
// RULE1: Scrubbing on corrects every detected single-bit error
// RULE2: Correction rewrites the bit in place
// RULE3: Each error queued, four messages at most
// RULE4: Message holds sector, type and location
// RULE5: Pending output high while queue nonempty
// RULE6: Pending falls only when retriever empties queue
// RULE7: Pending pin needs pin enable and detection
// RULE8: Two 32-bit words, sector word upper
// RULE9: Sector word: address 23:16, count-1 3:0
// RULE10: Location: type 31:29, corrected bit 28
// RULE11: Location: bit 23:12, row/frame 11:0
// RULE12: Location 23:0 zero unless scrubbed single-bit
// RULE13: Correction leaves the message queued
// RULE14: Scrub off: sector mitigation stops after error
// RULE15: Faulty config runs until correction completes
// RULE16: High priority sectors checked before others
// RULE17: Minimum interval 0 to 10000 ms
// RULE18: Priority sectors ignore interval, others obey
// RULE19: Detection runs only when enabled
// RULE20: Correction runs only when scrubbing enabled
// RULE21: FIFO order, sector word first, then location
// RULE22: Full queue drops new messages
module configuration_memory_seu_error_queue
  import seu_queue_pkg::*;
#(
  parameter int SECTORS = SECTOR_COUNT,
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [4:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Sector check engine
  output logic check_start_o,
  output logic [7:0] check_sector_o,
  input wire logic res_valid_i,
  input wire logic res_err_i,
  input wire logic res_multi_i,
  input wire logic [11:0] res_bit_i,
  input wire logic [11:0] res_index_i,
  // In-place bit correction
  output logic fix_start_o,
  output logic [7:0] fix_sector_o,
  output logic [11:0] fix_bit_o,
  output logic [11:0] fix_index_o,
  input wire logic fix_done_i,
  // Message stream
  output logic stream_valid_o,
  output logic [31:0] stream_data_o,
  output logic stream_last_o,
  input wire logic stream_ready_i,
  // Error pending pin
  output logic error_pending_o
);
  localparam int SW = $clog2(SECTORS);
  localparam int TW = $clog2(MS_TICK_CYCLES + 1);
  localparam int PW = $clog2(QUEUE_DEPTH);
  localparam int CW = PW + 1;
  logic [2:0] ctrl_reg;
  logic [13:0] interval_reg;
  logic [SECTORS-1:0] prio_reg;
  logic [SECTORS-1:0] mitig_off_reg;
  logic [7:0] drop_reg;
  logic [31:0] rdata_reg;
  scan_state_type state_reg;
  logic [SECTORS-1:0] prio_left_reg;
  logic [SW-1:0] norm_ptr_reg;
  logic [SW-1:0] cur_sector_reg;
  logic cur_prio_reg;
  logic [13:0] wait_ms_reg;
  logic [TW-1:0] tick_reg;
  logic [3:0] err_cnt_reg [SECTORS];
  logic [63:0] q_mem [QUEUE_DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] q_count_reg;
  logic word_sel_reg;
  logic detect_en;
  logic scrub_en;
  logic ms_tick;
  logic interval_done;
  logic [SECTORS-1:0] eligible;
  logic [SECTORS-1:0] prio_pend;
  logic pick_valid;
  logic pick_prio;
  logic [SW-1:0] pick_sector;
  logic norm_step;
  logic log_evt;
  logic fix_need;
  logic q_full;
  logic push;
  logic pop;
  logic [31:0] sect_word;
  logic [31:0] loc_word;
  assign detect_en = ctrl_reg[CTRL_DETECT_BIT];
  assign scrub_en = ctrl_reg[CTRL_SCRUB_BIT];
  // Register writes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= CTRL_RESET;
      interval_reg <= INTERVAL_RESET;
      prio_reg <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == OFS_CTRL) begin
        ctrl_reg <= reg_wdata_i[2:0];
      end
      if (reg_addr_i == OFS_INTERVAL) begin
        if (reg_wdata_i[13:0] > INTERVAL_MAX_MS ||
            reg_wdata_i[31:14] != '0) begin
          interval_reg <= INTERVAL_MAX_MS; // RULE17
        end else begin
          interval_reg <= reg_wdata_i[13:0]; // RULE17
        end
      end
      if (reg_addr_i == OFS_PRIO) begin
        prio_reg <= reg_wdata_i[SECTORS-1:0];
      end
    end
  end
  // Sectors with mitigation stopped; write one to re-arm, set wins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mitig_off_reg <= '0;
    end else begin
      for (int i = 0; i < SECTORS; i++) begin
        if (log_evt && !scrub_en && cur_sector_reg == SW'(i)) begin
          mitig_off_reg[i] <= 1'b1; // RULE14
        end else if (reg_wr_i && reg_addr_i == OFS_MITIG_OFF &&
                     reg_wdata_i[i]) begin
          mitig_off_reg[i] <= 1'b0;
        end
      end
    end
  end
  // Register reads
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= '0;
    end else if (reg_rd_i) begin
      rdata_reg <= '0;
      unique case (reg_addr_i)
        OFS_CTRL: rdata_reg[2:0] <= ctrl_reg;
        OFS_INTERVAL: rdata_reg[13:0] <= interval_reg;
        OFS_PRIO: rdata_reg[SECTORS-1:0] <= prio_reg;
        OFS_MITIG_OFF: rdata_reg[SECTORS-1:0] <= mitig_off_reg;
        OFS_STATUS: begin
          rdata_reg[STAT_COUNT_LO +: CW] <= q_count_reg;
          rdata_reg[STAT_PEND_BIT] <= (q_count_reg != '0);
          rdata_reg[STAT_DROP_LO +: 8] <= drop_reg;
        end
        default: rdata_reg <= '0;
      endcase
    end
  end
  assign reg_rdata_o = rdata_reg;
  // Millisecond enable pulse
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || ms_tick) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + TW'(1);
    end
  end
  assign ms_tick = (tick_reg == TW'(MS_TICK_CYCLES - 1));
  // Candidate selection: priority round first, then one normal sector
  assign eligible = ~mitig_off_reg & {SECTORS{detect_en}}; // RULE19 RULE14
  assign prio_pend = prio_left_reg & prio_reg & eligible;
  assign interval_done = (wait_ms_reg == '0);
  always_comb begin
    pick_valid = 1'b0;
    pick_prio = 1'b0;
    pick_sector = '0;
    norm_step = 1'b0;
    if (prio_pend != '0) begin
      pick_valid = 1'b1; // RULE16 RULE18
      pick_prio = 1'b1;
      for (int i = SECTORS - 1; i >= 0; i--) begin
        if (prio_pend[i]) begin
          pick_sector = SW'(i);
        end
      end
    end else if (interval_done) begin
      norm_step = 1'b1; // RULE17 RULE18
      pick_sector = norm_ptr_reg;
      pick_valid = eligible[norm_ptr_reg] && !prio_reg[norm_ptr_reg];
    end
  end
  // Scan sequencer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_PICK;
      cur_sector_reg <= '0;
      cur_prio_reg <= 1'b0;
      check_start_o <= 1'b0;
    end else begin
      check_start_o <= 1'b0;
      unique case (state_reg)
        ST_PICK: begin
          if (pick_valid) begin
            state_reg <= ST_WAIT;
            cur_sector_reg <= pick_sector;
            cur_prio_reg <= pick_prio;
            check_start_o <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (res_valid_i) begin
            state_reg <= fix_need ? ST_FIX : ST_PICK;
          end
        end
        ST_FIX: begin
          if (fix_done_i) begin
            state_reg <= ST_PICK; // RULE15
          end
        end
        default: state_reg <= ST_PICK;
      endcase
    end
  end
  assign check_sector_o = 8'(cur_sector_reg);
  // Priority round bookkeeping
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prio_left_reg <= '0;
    end else if (state_reg == ST_PICK) begin
      if (pick_valid && pick_prio) begin
        prio_left_reg[pick_sector] <= 1'b0;
      end else if (prio_pend == '0) begin
        prio_left_reg <= prio_reg & eligible; // RULE16
      end
    end
  end
  // Normal sweep pointer and interval wait
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      norm_ptr_reg <= '0;
      wait_ms_reg <= '0;
    end else if (state_reg == ST_PICK && norm_step) begin
      if (norm_ptr_reg == SW'(SECTORS - 1)) begin
        norm_ptr_reg <= '0;
        wait_ms_reg <= interval_reg; // RULE17
      end else begin
        norm_ptr_reg <= norm_ptr_reg + SW'(1);
      end
    end else if (ms_tick && !interval_done) begin
      wait_ms_reg <= wait_ms_reg - 14'h0001;
    end
  end
  // Result handling
  assign log_evt = (state_reg == ST_WAIT) && res_valid_i && res_err_i;
  assign fix_need = log_evt && scrub_en && !res_multi_i; // RULE1 RULE20
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fix_start_o <= 1'b0;
      fix_sector_o <= '0;
      fix_bit_o <= '0;
      fix_index_o <= '0;
    end else begin
      fix_start_o <= fix_need; // RULE2
      if (fix_need) begin
        fix_sector_o <= 8'(cur_sector_reg);
        fix_bit_o <= res_bit_i;
        fix_index_o <= res_index_i;
      end
    end
  end

  // Per-sector error counts, saturating
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < SECTORS; i++) begin
        err_cnt_reg[i] <= '0;
      end
    end else if (log_evt && err_cnt_reg[cur_sector_reg] != 4'hf) begin
      err_cnt_reg[cur_sector_reg] <= err_cnt_reg[cur_sector_reg] + 4'h1;
    end
  end

  // Message assembly
  always_comb begin
    sect_word = '0;
    sect_word[SECT_ADDR_LO +: 8] = 8'(cur_sector_reg); // RULE9
    sect_word[SECT_CNT_LO +: 4] = err_cnt_reg[cur_sector_reg]; // RULE9
    loc_word = '0;
    loc_word[LOC_TYPE_LO +: 3] =
      res_multi_i ? TYPE_MULTI : TYPE_SINGLE; // RULE10
    loc_word[LOC_FIXED_BIT] = fix_need; // RULE10
    if (fix_need) begin
      loc_word[LOC_POS_LO +: 12] = res_bit_i; // RULE11 RULE12
      loc_word[LOC_IDX_LO +: 12] = res_index_i; // RULE11
    end
  end

  // Message queue
  assign q_full = (q_count_reg == CW'(QUEUE_DEPTH));
  assign push = log_evt && !q_full; // RULE3 RULE22
  assign pop = stream_valid_o && stream_ready_i && word_sel_reg;
  always_ff @(posedge clk_i) begin
    if (push) begin
      q_mem[wr_ptr_reg] <= {sect_word, loc_word}; // RULE4 RULE8
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      q_count_reg <= '0;
      drop_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PW'(1); // RULE21 RULE13
      end
      if (push && !pop) begin
        q_count_reg <= q_count_reg + CW'(1);
      end else if (pop && !push) begin
        q_count_reg <= q_count_reg - CW'(1); // RULE6
      end
      if (log_evt && q_full && drop_reg != 8'hff) begin
        drop_reg <= drop_reg + 8'h01; // RULE22
      end
    end
  end

  // Word phase of the head message
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      word_sel_reg <= 1'b0;
    end else if (stream_valid_o && stream_ready_i) begin
      word_sel_reg <= !word_sel_reg; // RULE21
    end
  end
  assign stream_valid_o = (q_count_reg != '0);
  assign stream_last_o = word_sel_reg;
  assign stream_data_o = word_sel_reg ? q_mem[rd_ptr_reg][31:0] :
                         q_mem[rd_ptr_reg][63:32]; // RULE8 RULE21
  assign error_pending_o = stream_valid_o && detect_en &&
                           ctrl_reg[CTRL_PIN_BIT]; // RULE5 RULE7
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  queue_cap_a: assert property ( // RULE3
    q_count_reg <= CW'(QUEUE_DEPTH))
    else $error("queue count above depth");
  full_drop_a: assert property ( // RULE22
    log_evt && q_full && !pop |=> q_full && $stable(wr_ptr_reg))
    else $error("full queue accepted a message");
  pend_rise_a: assert property ( // RULE5
    log_evt && detect_en && ctrl_reg[CTRL_PIN_BIT] &&
    !(reg_wr_i && reg_addr_i == OFS_CTRL) |=> error_pending_o)
    else $error("pending not raised after error");
  pend_fall_a: assert property ( // RULE6
    $fell(error_pending_o) && $stable(ctrl_reg) |-> q_count_reg == '0)
    else $error("pending fell with messages queued");
  fix_issue_a: assert property ( // RULE1
    log_evt && scrub_en && !res_multi_i |=> fix_start_o ##1
    state_reg == ST_FIX)
    else $error("single-bit error not corrected");
  fix_gate_a: assert property ( // RULE20
    fix_start_o |-> $past(scrub_en) && $past(log_evt))
    else $error("correction without scrubbing");
  mitig_stop_a: assert property ( // RULE14
    log_evt && !scrub_en |=> mitig_off_reg[cur_sector_reg] ##1
    !(check_start_o && check_sector_o == 8'($past(cur_sector_reg, 2))))
    else $error("mitigation not stopped");
  detect_gate_a: assert property ( // RULE19
    !detect_en && $past(!detect_en) |-> !check_start_o)
    else $error("check while detection off");
  loc_zero_a: assert property ( // RULE12
    push && !fix_need |-> loc_word[23:0] == 24'h000000)
    else $error("location reported without scrub");
  prio_first_a: assert property ( // RULE16
    state_reg == ST_PICK && prio_pend != '0 |=> check_start_o &&
    cur_prio_reg)
    else $error("normal sector before priority");
  word_order_a: assert property ( // RULE21
    stream_valid_o && stream_ready_i && !word_sel_reg |=>
    stream_last_o && stream_valid_o && $stable(rd_ptr_reg))
    else $error("location word out of order");
  full_c: cover property (q_full ##1 log_evt);
  fix_c: cover property (fix_start_o ##[1:20] fix_done_i);
  pop_c: cover property (pop ##1 stream_valid_o);
  prio_c: cover property (check_start_o && cur_prio_reg);
endmodule : configuration_memory_seu_error_queue

// *** verification/seu_far_side.sv ***
`timescale 1ns/1ps

module seu_far_side (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Sector check and correction
  input wire logic check_start_i,
  input wire logic [7:0] check_sector_i,
  input wire logic fix_start_i,
  output logic res_valid_o,
  output logic res_err_o,
  output logic [11:0] res_bit_o,
  output logic [11:0] res_index_o,
  output logic fix_done_o,
  // Upset injection
  input wire logic arm_i,
  input wire logic [7:0] arm_mask_i
);
  logic [7:0] upset_reg;
  logic [1:0] chk_dly_reg;
  logic [2:0] fix_dly_reg;
  logic noise_reg;
  logic hit;
  logic [7:0] clr;

  assign hit = upset_reg[check_sector_i[2:0]];
  assign clr = res_valid_o ? (8'h01 << check_sector_i[2:0]) : 8'h00;
  assign res_valid_o = chk_dly_reg[1];
  assign fix_done_o = fix_dly_reg[2];
  // Idle result lines toggle so stale values never pass
  assign res_err_o = res_valid_o ? hit : noise_reg;
  assign res_bit_o = res_valid_o ? {4'h5, check_sector_i} : {12{noise_reg}};
  assign res_index_o = res_valid_o ? 12'h0c3 : {12{~noise_reg}};

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      upset_reg <= 8'h00;
      chk_dly_reg <= 2'h0;
      fix_dly_reg <= 3'h0;
      noise_reg <= 1'b0;
    end else begin
      upset_reg <= (upset_reg & ~clr) | (arm_i ? arm_mask_i : 8'h00);
      chk_dly_reg <= {chk_dly_reg[0], check_start_i};
      fix_dly_reg <= {fix_dly_reg[1:0], fix_start_i};
      noise_reg <= ~noise_reg;
    end
  end
endmodule : seu_far_side

// *** verification/configuration_memory_seu_error_queue_tb_top.sv ***
`timescale 1ns/1ps

module configuration_memory_seu_error_queue_tb_top;
  import seu_queue_pkg::*;
  localparam int TICK = 10;
  typedef struct packed {
    logic [2:0] ctrl;
    logic [7:0] mask;
    logic multi;
    logic [31:0] sect;
    logic [31:0] loc;
  } row_type;
  row_type rows [4] = '{
    '{3'h7, 8'h04, 1'b0, 32'h00020000, 32'h305020c3},
    '{3'h7, 8'h20, 1'b1, 32'h00050000, 32'h40000000},
    '{3'h7, 8'h04, 1'b0, 32'h00020001, 32'h305020c3},
    '{3'h5, 8'h40, 1'b0, 32'h00060000, 32'h20000000}
  };
  logic [7:0] full_sec [5] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h07};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [4:0] reg_addr_i = 5'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic res_multi_i = 1'b0;
  logic stream_ready_i = 1'b0;
  logic arm = 1'b0;
  logic [7:0] arm_mask = 8'h00;
  logic [31:0] reg_rdata_o, stream_data_o;
  logic [11:0] res_bit_i, res_index_i, fix_bit_o, fix_index_o;
  logic [7:0] check_sector_o, fix_sector_o;
  logic check_start_o, res_valid_i, res_err_i, fix_start_o, fix_done_i;
  logic stream_valid_o, stream_last_o, error_pending_o;
  logic [31:0] got_q [$];
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  int prio_cnt = 0;
  int norm_cnt = 0;
  int last_norm = 0;
  int min_gap = 100000;
  logic watch = 1'b0;

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  configuration_memory_seu_error_queue #(.MS_TICK_CYCLES(TICK)) dut (
    .clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .check_start_o, .check_sector_o, .res_valid_i, .res_err_i,
    .res_multi_i, .res_bit_i, .res_index_i, .fix_start_o,
    .fix_sector_o, .fix_bit_o, .fix_index_o, .fix_done_i,
    .stream_valid_o, .stream_data_o, .stream_last_o, .stream_ready_i,
    .error_pending_o
  );

  seu_far_side far (
    .clk_i, .sys_rst_i, .check_start_i(check_start_o),
    .check_sector_i(check_sector_o), .fix_start_i(fix_start_o),
    .res_valid_o(res_valid_i), .res_err_o(res_err_i),
    .res_bit_o(res_bit_i), .res_index_o(res_index_i),
    .fix_done_o(fix_done_i), .arm_i(arm), .arm_mask_i(arm_mask)
  );

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t word %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t flag %b exp %b", $time, got, exp);
    end
  endtask : cmp_flag

  task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : reg_write

  task automatic reg_check(input logic [4:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    cmp_word(reg_rdata_o, exp);
  endtask : reg_check

  task automatic inject(input logic [7:0] m, input logic mult);
    arm_mask <= m;
    res_multi_i <= mult;
    arm <= 1'b1;
    @(posedge clk_i);
    arm <= 1'b0;
  endtask : inject

  task automatic wait_valid();
    repeat (400) if (stream_valid_o !== 1'b1) @(posedge clk_i);
  endtask : wait_valid

  task automatic wait_clear(input logic [7:0] m);
    @(posedge clk_i);
    repeat (400) if ((far.upset_reg & m) != 8'h00) @(posedge clk_i);
  endtask : wait_clear

  // Host side shifts words out, one per accepted edge
  task automatic drain(input int words);
    int n;
    n = 0;
    stream_ready_i <= 1'b1;
    repeat (200) if (n < words) begin
      @(posedge clk_i);
      if (stream_valid_o === 1'b1) begin
        cmp_flag(stream_last_o, n[0]);
        got_q.push_back(stream_data_o);
        n++;
      end
    end
    stream_ready_i <= 1'b0;
  endtask : drain

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
    if (watch && check_start_o && check_sector_o == 8'h05) prio_cnt++;
    if (watch && check_start_o && check_sector_o == 8'h01) begin
      norm_cnt++;
      if (last_norm > 0 && cycles - last_norm < min_gap)
        min_gap = cycles - last_norm;
      last_norm = cycles;
    end
  end

  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    foreach (rows[i]) begin
      got_q.delete();
      reg_write(OFS_CTRL, {29'h0, rows[i].ctrl});
      inject(rows[i].mask, rows[i].multi);
      wait_valid();
      repeat (20) @(posedge clk_i);
      cmp_flag(error_pending_o, 1'b1);
      drain(2);
      cmp_word(got_q[0], rows[i].sect);
      cmp_word(got_q[1], rows[i].loc);
      @(posedge clk_i);
      cmp_flag(error_pending_o, 1'b0);
    end
    cmp_word({fix_sector_o, fix_bit_o, fix_index_o}, 32'h025020c3);
    reg_check(OFS_MITIG_OFF, 32'h00000040);
    inject(8'h40, 1'b0);
    repeat (150) @(posedge clk_i);
    cmp_flag(stream_valid_o, 1'b0);
    $display("message rows done");
    reg_write(OFS_CTRL, 32'h00000007);
    reg_write(OFS_PRIO, 32'h00000020);
    reg_write(OFS_INTERVAL, 32'h00000005);
    watch = 1'b1;
    repeat (600) @(posedge clk_i);
    watch = 1'b0;
    cmp_flag(prio_cnt > norm_cnt, 1'b1);
    cmp_flag(min_gap >= 5 * TICK && norm_cnt > 1, 1'b1);
    $display("priority and interval done");
    got_q.delete();
    foreach (full_sec[i]) begin
      inject(8'h01 << full_sec[i][2:0], 1'b1);
      wait_clear(8'h01 << full_sec[i][2:0]);
    end
    reg_check(OFS_STATUS, 32'h00000114);
    drain(2);
    @(posedge clk_i);
    cmp_flag(error_pending_o, 1'b1);
    drain(6);
    for (int i = 0; i < 4; i++) begin
      cmp_word(got_q[2 * i], {8'h00, full_sec[i], 16'h0000});
      cmp_word(got_q[2 * i + 1], 32'h40000000);
    end
    @(posedge clk_i);
    cmp_flag(error_pending_o, 1'b0);
    reg_check(OFS_STATUS, 32'h00000100);
    $display("full queue done");
    reg_write(OFS_CTRL, 32'h00000006);
    inject(8'h08, 1'b1);
    repeat (150) @(posedge clk_i);
    cmp_flag(stream_valid_o, 1'b0);
    reg_write(OFS_CTRL, 32'h00000003);
    inject(8'h08, 1'b1);
    wait_valid();
    cmp_flag(stream_valid_o, 1'b1);
    cmp_flag(error_pending_o, 1'b0);
    reg_write(OFS_CTRL, 32'h00000007);
    @(posedge clk_i);
    cmp_flag(error_pending_o, 1'b1);
    $display("enables done");
    reg_write(OFS_INTERVAL, 32'h00003fff);
    reg_check(OFS_INTERVAL, {18'h0, INTERVAL_MAX_MS});
    reg_check(5'h14, 32'h00000000);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    cmp_flag(stream_valid_o, 1'b0);
    cmp_flag(error_pending_o, 1'b0);
    reg_check(OFS_CTRL, 32'h00000000);
    reg_check(OFS_STATUS, 32'h00000000);
    $display("registers and reset done");
    complete_run();
  end
endmodule : configuration_memory_seu_error_queue_tb_top
